// file: rtl/gsr_pkg.sv
// shared constants for the status reporting block
package gsr_pkg;

   // ------------------------------------------------------------
   // terminator modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      GSR_TERM_LF_EOI   = 2'h0,
      GSR_TERM_LF_ONLY  = 2'h1,
      GSR_TERM_EOI_ONLY = 2'h2,
      GSR_TERM_NONE     = 2'h3
   } gsr_term_t;

   // ------------------------------------------------------------
   // status summary byte bit positions
   // ------------------------------------------------------------
   localparam int STB_PRE = 0;
   localparam int STB_FSC = 1;
   localparam int STB_FSB = 2;
   localparam int STB_FSA = 3;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;
   localparam int STB_NU7 = 7;

   // ------------------------------------------------------------
   // standard event flag bit positions
   // ------------------------------------------------------------
   localparam int ESR_OPC = 0;
   localparam int ESR_RQC = 1;
   localparam int ESR_QYE = 2;
   localparam int ESR_DDE = 3;
   localparam int ESR_EXE = 4;
   localparam int ESR_CME = 5;
   localparam int ESR_URQ = 6;
   localparam int ESR_PON = 7;

   // ------------------------------------------------------------
   // reset values and characters
   // ------------------------------------------------------------
   localparam logic [7:0] ESR_RST   = 8'h80;
   localparam logic [7:0] SRE_RST   = 8'h00;
   localparam logic [7:0] ESE_RST   = 8'h00;
   localparam logic [7:0] SRE_WMASK = 8'hBF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] CHR_LF    = 8'h0A;
   localparam logic [7:0] CHR_ONE   = 8'h31;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [1:0] HDR_LEN   = 2'h3;
   localparam logic [1:0] HDR_ZERO  = 2'h0;
   localparam logic [1:0] HDR_STEP  = 2'h1;

endpackage : gsr_pkg

// file: rtl/gsr_status.sv
// status byte, standard event flags and response formatting
`timescale 1ns/1ps
// Operation
// - header off drops three leading bytes of each response; header on restores them.
// - four terminators: LF with END, LF only, END on last byte, nothing.
// - terminator defaults to LF with END and returns there on device clear.
// - in END modes the final byte carries EOI.
// - operation complete command sets event bit 0 once pending work finishes.
// - operation complete query queues character 1 once pending work finishes.
// - clear status clears event flags and flushes the output queue.
// - status bit 0 shows any pulse/ramp error bit set.
// - status bits 1, 2, 3 show calibration failures c, b, a.
// - status bit 4 true exactly while the output queue holds data.
// - status bit 5 true when any enabled standard event is set.
// - bit 6 is summary on query, request flag on poll; bit 7 zero.
// - serial poll returns one byte, request flag on bit 6, lines active low.
// - serial poll clears request flag until a new reason arises.
// - service request line stays asserted until polled; controller polls promptly.
// - status query returns byte with summary and changes nothing.
// - service request mask written and read; bit 6 ignored and reads zero.
// - event flags clear on read and on clear status; power on leaves only bit 7 set.
// - bit 0 operation complete, bit 1 never set, bit 2 query error.
// - bit 3 marks unrealizable parameter combination; processing continues.
// - bit 4 out-of-range data; bit 5 syntax or unknown command errors.
// - bit 6 on manual button press; bit 7 after power cycle.
// - event enable mask selects which flags feed status bit 5.
// - reading without a terminated query sets query error and clears queue.
module gsr_status #(
   parameter int FSA_W = 16,
   parameter int FSB_W = 8,
   parameter int FSC_W = 16,
   parameter int PRE_W = 8
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             hdr_off_i,
   input  wire logic             hdr_on_i,
   input  wire logic             term_wr_i,
   input  wire logic [1:0]       term_sel_i,
   input  wire logic             dev_clr_i,
   input  wire logic             opc_cmd_i,
   input  wire logic             opc_qry_i,
   input  wire logic             ops_busy_i,
   input  wire logic             cls_i,
   input  wire logic             sre_wr_i,
   input  wire logic [7:0]       sre_wdata_i,
   input  wire logic             ese_wr_i,
   input  wire logic [7:0]       ese_wdata_i,
   input  wire logic             esr_rd_i,
   input  wire logic             stb_qry_i,
   input  wire logic             spoll_i,
   input  wire logic             talk_req_i,
   input  wire logic             rd_unterm_i,
   input  wire logic             dde_i,
   input  wire logic             exe_i,
   input  wire logic             cme_i,
   input  wire logic             manual_btn_i,
   input  wire logic [PRE_W-1:0] pr_err_i,
   input  wire logic [FSA_W-1:0] cal_fail_a_i,
   input  wire logic [FSB_W-1:0] cal_fail_b_i,
   input  wire logic [FSC_W-1:0] cal_fail_c_i,
   input  wire logic             resp_valid_i,
   input  wire logic [7:0]       resp_data_i,
   input  wire logic             resp_last_i,
   output logic                  resp_ready_o,
   input  wire logic             tx_ack_i,
   output logic                  tx_valid_o,
   output logic [7:0]            tx_data_o,
   output logic                  tx_eoi_o,
   output logic                  flush_o,
   output logic [7:0]            sre_o,
   output logic [7:0]            ese_o,
   output logic [7:0]            esr_o,
   output logic [7:0]            stb_o,
   output logic [7:0]            spoll_dio_n_o,
   output logic                  srq_n_o,
   output logic                  mav_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   gsr_pkg::gsr_term_t term_q;
   logic               hdr_off_q;
   logic [1:0]         hc_q;
   logic [1:0]         hc_d;
   logic               tx_v_d;
   logic [7:0]         tx_dat_d;
   logic               tx_eoi_d;
   logic               lf_q;
   logic               lf_d;
   logic               one_q;
   logic               one_d;
   logic               tx_ld;
   logic               ready_d;
   logic               mav_d;
   logic               rx;
   logic               flush;
   logic               lf_mode;
   logic               opc_wait_q;
   logic               oq_wait_q;
   logic               opc_done;
   logic               oq_done;
   logic               qerr;
   logic [7:0]         esr_q;
   logic [7:0]         set_v;
   logic [7:0]         stb_v;
   logic [7:0]         stb_q;
   logic               mss_q;
   logic               mss_d;
   logic               mss_rise;
   logic               rqs_q;
   logic               btn_s;
   logic               btn_p_q;

   assign rx       = resp_valid_i && resp_ready_o;
   assign flush    = cls_i || rd_unterm_i;
   assign lf_mode  = (term_q == gsr_pkg::GSR_TERM_LF_EOI) || (term_q == gsr_pkg::GSR_TERM_LF_ONLY);
   assign opc_done = opc_wait_q && !ops_busy_i;
   assign oq_done  = oq_wait_q && !ops_busy_i;

   // ------------------------------------------------------------
   // manual button input
   // ------------------------------------------------------------
   gsr_sync u_btn_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       (manual_btn_i),
      .q_o       (btn_s)
   );

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         btn_p_q <= 1'b0;
      end else begin
         btn_p_q <= btn_s;
      end
   end

   // ------------------------------------------------------------
   // format settings
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         term_q <= gsr_pkg::GSR_TERM_LF_EOI;
      end else if (dev_clr_i) begin
         term_q <= gsr_pkg::GSR_TERM_LF_EOI;
      end else if (term_wr_i) begin
         term_q <= gsr_pkg::gsr_term_t'(term_sel_i);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hdr_off_q <= 1'b0;
      end else if (hdr_off_i) begin
         hdr_off_q <= 1'b1;
      end else if (hdr_on_i) begin
         hdr_off_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pending operation waits
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         opc_wait_q <= 1'b0;
      end else if (opc_cmd_i) begin
         opc_wait_q <= 1'b1;
      end else if (opc_done) begin
         opc_wait_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         oq_wait_q <= 1'b0;
      end else if (flush) begin
         oq_wait_q <= 1'b0;
      end else if (opc_qry_i) begin
         oq_wait_q <= 1'b1;
      end else if (oq_done) begin
         oq_wait_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // talker: header skip, data, terminator
   // ------------------------------------------------------------
   always_comb begin
      tx_v_d   = tx_valid_o;
      tx_dat_d = tx_data_o;
      tx_eoi_d = tx_eoi_o;
      lf_d     = lf_q;
      one_d    = one_q;
      hc_d     = hc_q;
      tx_ld    = 1'b0;
      if (oq_done) begin
         one_d = 1'b1;
      end
      if (tx_valid_o && tx_ack_i) begin
         tx_v_d = 1'b0;
      end
      if (flush) begin
         tx_v_d = 1'b0;
         lf_d   = 1'b0;
         one_d  = 1'b0;
         hc_d   = gsr_pkg::HDR_ZERO;
      end else if (!tx_v_d) begin
         if (lf_q) begin
            tx_ld    = 1'b1;
            tx_dat_d = gsr_pkg::CHR_LF;
            tx_eoi_d = (term_q == gsr_pkg::GSR_TERM_LF_EOI);
            lf_d     = 1'b0;
         end else if (rx) begin
            if (hdr_off_q && hc_q != gsr_pkg::HDR_LEN) begin
               hc_d = hc_q + gsr_pkg::HDR_STEP;
            end else begin
               tx_ld    = 1'b1;
               tx_dat_d = resp_data_i;
               tx_eoi_d = resp_last_i && (term_q == gsr_pkg::GSR_TERM_EOI_ONLY);
               lf_d     = resp_last_i && lf_mode;
            end
            if (resp_last_i) begin
               hc_d = gsr_pkg::HDR_ZERO;
            end
         end else if (one_q) begin
            tx_ld    = 1'b1;
            tx_dat_d = gsr_pkg::CHR_ONE;
            tx_eoi_d = (term_q == gsr_pkg::GSR_TERM_EOI_ONLY);
            lf_d     = lf_mode;
            one_d    = 1'b0;
         end
      end
      if (tx_ld) begin
         tx_v_d = 1'b1;
      end
      // half rate on the response port buys a registered ready
      ready_d = !flush && !tx_v_d && !lf_d;
      mav_d   = tx_v_d || lf_d || one_d || resp_valid_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_valid_o   <= 1'b0;
         tx_data_o    <= gsr_pkg::BYTE_ZERO;
         tx_eoi_o     <= 1'b0;
         lf_q         <= 1'b0;
         one_q        <= 1'b0;
         hc_q         <= gsr_pkg::HDR_ZERO;
         resp_ready_o <= 1'b0;
      end else begin
         tx_valid_o   <= tx_v_d;
         tx_data_o    <= tx_dat_d;
         tx_eoi_o     <= tx_eoi_d;
         lf_q         <= lf_d;
         one_q        <= one_d;
         hc_q         <= hc_d;
         resp_ready_o <= ready_d;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mav_o   <= 1'b0;
         flush_o <= 1'b0;
      end else begin
         mav_o   <= mav_d;
         flush_o <= flush;
      end
   end

   // ------------------------------------------------------------
   // standard event flags
   // ------------------------------------------------------------
   // no output present or pending means the read is a query error
   assign qerr = rd_unterm_i || (talk_req_i && !mav_o && !oq_wait_q);

   always_comb begin
      set_v                   = gsr_pkg::BYTE_ZERO;
      set_v[gsr_pkg::ESR_OPC] = opc_done;
      set_v[gsr_pkg::ESR_QYE] = qerr;
      set_v[gsr_pkg::ESR_DDE] = dde_i;
      set_v[gsr_pkg::ESR_EXE] = exe_i;
      set_v[gsr_pkg::ESR_CME] = cme_i;
      set_v[gsr_pkg::ESR_URQ] = btn_s && !btn_p_q;
   end

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         esr_q <= gsr_pkg::ESR_RST;
      end else if (cls_i || esr_rd_i) begin
         esr_q <= set_v;
      end else begin
         esr_q <= esr_q | set_v;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         esr_o <= gsr_pkg::BYTE_ZERO;
      end else if (esr_rd_i) begin
         esr_o <= esr_q;
      end
   end

   // ------------------------------------------------------------
   // masks
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sre_o <= gsr_pkg::SRE_RST;
      end else if (sre_wr_i) begin
         sre_o <= sre_wdata_i & gsr_pkg::SRE_WMASK;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ese_o <= gsr_pkg::ESE_RST;
      end else if (ese_wr_i) begin
         ese_o <= ese_wdata_i;
      end
   end

   // ------------------------------------------------------------
   // status summary byte
   // ------------------------------------------------------------
   always_comb begin
      stb_v                   = gsr_pkg::BYTE_ZERO;
      stb_v[gsr_pkg::STB_PRE] = |pr_err_i;
      stb_v[gsr_pkg::STB_FSC] = |cal_fail_c_i;
      stb_v[gsr_pkg::STB_FSB] = |cal_fail_b_i;
      stb_v[gsr_pkg::STB_FSA] = |cal_fail_a_i;
      stb_v[gsr_pkg::STB_MAV] = mav_o;
      stb_v[gsr_pkg::STB_ESB] = |(esr_q & ese_o);
   end

   // bit 6 of the stored byte is always zero, so it never feeds the summary
   assign mss_d    = |(stb_q & sre_o);
   assign mss_rise = mss_d && !mss_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stb_q <= gsr_pkg::BYTE_ZERO;
         mss_q <= 1'b0;
      end else begin
         stb_q <= stb_v;
         mss_q <= mss_d;
      end
   end

   // ------------------------------------------------------------
   // request service and serial poll
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rqs_q <= 1'b0;
      end else if (mss_rise) begin
         rqs_q <= 1'b1;
      end else if (spoll_i) begin
         rqs_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         srq_n_o <= 1'b1;
      end else begin
         srq_n_o <= !(mss_rise || (rqs_q && !spoll_i));
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         spoll_dio_n_o <= gsr_pkg::BYTE_ONES;
      end else if (spoll_i) begin
         spoll_dio_n_o <= ~{1'b0, rqs_q, stb_q[gsr_pkg::STB_ESB:gsr_pkg::STB_PRE]};
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stb_o <= gsr_pkg::BYTE_ZERO;
      end else if (stb_qry_i) begin
         stb_o <= {1'b0, mss_q, stb_q[gsr_pkg::STB_ESB:gsr_pkg::STB_PRE]};
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_hdr_skip: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rx && hdr_off_q && hc_q != gsr_pkg::HDR_LEN && !flush) |=> !tx_valid_o)
      else $error("header byte was sent while header is off");

   a_term_none: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (tx_ld && term_q == gsr_pkg::GSR_TERM_NONE) |=> !tx_eoi_o && !lf_q)
      else $error("terminator sent in no-terminator mode");

   a_term_dflt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      dev_clr_i |=> term_q == gsr_pkg::GSR_TERM_LF_EOI)
      else $error("device clear did not restore terminator");

   a_lf_eoi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (tx_ld && lf_q && term_q == gsr_pkg::GSR_TERM_LF_EOI) |=> tx_eoi_o && tx_data_o == gsr_pkg::CHR_LF)
      else $error("line feed lacks end marker");

   a_opc_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (opc_wait_q && !ops_busy_i) |=> esr_q[gsr_pkg::ESR_OPC] && !opc_wait_q)
      else $error("operation complete flag not set");

   a_cls_flush: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cls_i |=> !tx_valid_o && !lf_q && !one_q && flush_o)
      else $error("clear status left output pending");

   a_poll_bit6: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      spoll_i |=> spoll_dio_n_o[gsr_pkg::STB_RQS] == !$past(rqs_q) && spoll_dio_n_o[gsr_pkg::STB_NU7])
      else $error("poll byte bit 6 wrong");

   a_poll_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (spoll_i && !mss_rise) |=> !rqs_q && srq_n_o)
      else $error("poll did not clear request");

   a_srq_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rqs_q && !spoll_i) |=> rqs_q && !srq_n_o)
      else $error("service request dropped before poll");

   a_stb_query: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      stb_qry_i |=> stb_o == {1'b0, $past(mss_q), $past(stb_q[5:0])})
      else $error("status query value wrong");

   a_sre_bit6: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sre_wr_i |=> sre_o == (($past(sre_wdata_i)) & 8'hBF))
      else $error("service mask write wrong");

   a_esr_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (esr_rd_i && set_v == 8'h00) |=> esr_q == 8'h00 && esr_o == $past(esr_q))
      else $error("event read not destructive");

   a_rqc_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !esr_q[gsr_pkg::ESR_RQC])
      else $error("request control flag set");

   a_unterm: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_unterm_i |=> esr_q[gsr_pkg::ESR_QYE] && !tx_valid_o)
      else $error("unterminated read not handled");

endmodule : gsr_status

// file: rtl/gsr_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module gsr_sync (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ------------------------------------------------------------
   // accept a change only once two stages agree
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o <= 1'b0;
      end else if (s2_q == s3_q) begin
         q_o <= s3_q;
      end
   end

endmodule : gsr_sync

// file: tb/gsr_ctl_model.sv
// bus controller model: takes talker bytes, serial polls on a service request
`timescale 1ns/1ps
module gsr_ctl_model (
   input  wire logic       sys_clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_eoi_i,
   input  wire logic       srq_n_i,
   input  wire logic [3:0] dly_i,
   output logic            tx_ack_o = 1'b0,
   output logic            poll_o = 1'b0,
   output int              rx_cnt_o,
   output logic [7:0]      rx_last_o,
   output logic [7:0]      rx_prev_o,
   output logic            rx_eoi_o
);
   int w = 0;
   // ------------------------------------------------------------
   // byte acceptance, slowed by dly_i
   // ------------------------------------------------------------
   always @(negedge sys_clk_i) begin
      tx_ack_o <= 1'b0;
      if (tx_valid_i && !tx_ack_o) begin
         w <= w + 1;
         if (w >= int'(dly_i)) begin
            tx_ack_o  <= 1'b1;
            w         <= 0;
            rx_cnt_o  <= rx_cnt_o + 1;
            rx_prev_o <= rx_last_o;
            rx_last_o <= tx_data_i;
            rx_eoi_o  <= tx_eoi_i;
         end
      end
   end
   // prompt poll, so requests of other devices are not hidden
   always @(negedge sys_clk_i) begin
      poll_o <= !poll_o && !srq_n_i;
   end
endmodule : gsr_ctl_model

// file: tb/gsr_status_tb_top.sv
// testbench: masks, event flags, poll and response formatting
`timescale 1ns/1ps
module gsr_status_tb_top;
   logic        clk, rst, busy, btn, rv, rl, txv, txe, ack, flush, srq_n, mav, rdy, poll, reoi;
   logic [15:0] s;
   logic [1:0]  tsel;
   logic [3:0]  cal, dly;
   logic [7:0]  sw, ew, rd, txd, service_request_mask, ese, standard_event_flags, stb, spd, rlast, rprev;
   int          rcnt, num_errors, n_tests, k, c0, nfl;
   gsr_status u_dut (.sys_clk_i(clk), .rst_i(rst), .hdr_off_i(s[0]), .hdr_on_i(s[1]), .term_wr_i(s[2]),
      .term_sel_i(tsel), .dev_clr_i(s[3]), .opc_cmd_i(s[4]), .opc_qry_i(s[5]), .ops_busy_i(busy), .cls_i(s[6]),
      .sre_wr_i(s[7]), .sre_wdata_i(sw), .ese_wr_i(s[8]), .ese_wdata_i(ew), .esr_rd_i(s[9]), .stb_qry_i(s[10]),
      .spoll_i(poll), .talk_req_i(s[11]), .rd_unterm_i(s[12]), .dde_i(s[13]), .exe_i(s[14]), .cme_i(s[15]),
      .manual_btn_i(btn), .pr_err_i({7'h00, cal[0]}), .cal_fail_a_i({15'h0000, cal[3]}),
      .cal_fail_b_i({7'h00, cal[2]}), .cal_fail_c_i({cal[1], 15'h0000}), .resp_valid_i(rv), .resp_data_i(rd),
      .resp_last_i(rl), .resp_ready_o(rdy), .tx_ack_i(ack), .tx_valid_o(txv), .tx_data_o(txd), .tx_eoi_o(txe),
      .flush_o(flush), .sre_o(service_request_mask), .ese_o(ese), .esr_o(standard_event_flags), .stb_o(stb), .spoll_dio_n_o(spd),
      .srq_n_o(srq_n), .mav_o(mav));
   gsr_ctl_model u_ctl (.sys_clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd), .tx_eoi_i(txe), .srq_n_i(srq_n),
      .dly_i(dly), .tx_ack_o(ack), .poll_o(poll), .rx_cnt_o(rcnt), .rx_last_o(rlast), .rx_prev_o(rprev),
      .rx_eoi_o(reoi));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(negedge clk) nfl += int'(flush === 1'b1);
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk8
   task automatic tmo();
      if (k >= 40) begin
         num_errors++;
         end_of_test();
      end
   endtask : tmo
   task automatic pulse(input int i);
      s[i] = 1'b1;
      @(negedge clk);
      s = 16'h0000;
      @(negedge clk);
   endtask : pulse
   task automatic rx_chk(input int base, input int n, input logic [7:0] last, input logic eoi);
      for (k = 0; k < 40 && rcnt != base + n; k++) @(negedge clk);
      tmo();
      repeat (4) @(negedge clk);
      chk8("rx count", 8'(n), 8'(rcnt - base));
      chk8("rx last", last, rlast);
      chk8("rx eoi", {7'h00, eoi}, {7'h00, reoi});
   endtask : rx_chk
   task automatic send(input int n, input int en, input logic [7:0] last, input logic eoi);
      int base;
      base = rcnt;
      for (int i = 0; i < n; i++) begin
         rv = 1'b1;
         rd = 8'h41 + 8'(i);
         rl = (i == n - 1);
         for (k = 0; k < 40 && rdy !== 1'b1; k++) @(negedge clk);
         tmo();
         @(negedge clk);
      end
      rv = 1'b0;
      rx_chk(base, en, last, eoi);
   endtask : send
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      {s, rst, busy, btn, rv, rl, tsel, cal, dly, sw, ew, rd} = {16'h0000, 1'b1, 38'h0};
      num_errors = 0;
      n_tests = 0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk8("poll idle", 8'hFF, spd);
      pulse(9); chk8("esr pon", 8'h80, standard_event_flags);
      pulse(9); chk8("esr read", 8'h00, standard_event_flags);
      sw = 8'hFF; pulse(7); chk8("sre", 8'hBF, service_request_mask);
      sw = 8'h00; pulse(7); chk8("sre", 8'h00, service_request_mask);
      pulse(13); pulse(14); pulse(15); pulse(9); chk8("esr err", 8'h38, standard_event_flags);
      busy = 1'b1; pulse(4); repeat (3) @(negedge clk); pulse(9); chk8("esr busy", 8'h00, standard_event_flags);
      busy = 1'b0; repeat (3) @(negedge clk); pulse(9); chk8("esr opc", 8'h01, standard_event_flags);
      btn = 1'b1; repeat (8) @(negedge clk); btn = 1'b0; repeat (8) @(negedge clk);
      pulse(9); chk8("esr btn", 8'h40, standard_event_flags);
      pulse(11); pulse(9); chk8("esr qye", 8'h04, standard_event_flags);
      pulse(12); pulse(9); chk8("esr unterm", 8'h04, standard_event_flags);
      pulse(14); pulse(6); pulse(9); chk8("esr cls", 8'h00, standard_event_flags);
      chk8("flushes", 8'h02, 8'(nfl));
      for (int b = 0; b < 4; b++) begin
         cal = 4'h1 << b;
         repeat (3) @(negedge clk);
         pulse(10); chk8("stb cal", 8'h01 << b, stb);
      end
      cal = 4'h0;
      ew = 8'h10; pulse(8); chk8("ese", 8'h10, ese);
      sw = 8'h20; pulse(7); pulse(14);
      for (k = 0; k < 40 && srq_n !== 1'b0; k++) @(negedge clk);
      tmo();
      for (k = 0; k < 40 && srq_n !== 1'b1; k++) @(negedge clk);
      tmo();
      chk8("poll byte", 8'h9F, spd);
      repeat (6) @(negedge clk);
      chk8("srq after poll", 8'h01, {7'h00, srq_n});
      pulse(10); pulse(10); chk8("stb mss", 8'h60, stb);
      pulse(9); chk8("esr exe", 8'h10, standard_event_flags);
      for (int m = 0; m < 4; m++) begin
         tsel = 2'(m);
         dly = {2'h0, m[0], 1'b0};
         pulse(2); send(4, (m < 2) ? 5 : 4, (m < 2) ? 8'h0A : 8'h44, m == 0 || m == 2);
      end
      pulse(0); send(4, 1, 8'h44, 1'b0);
      pulse(3); send(4, 2, 8'h0A, 1'b1);
      pulse(1); send(2, 3, 8'h0A, 1'b1);
      c0 = rcnt; pulse(5); chk8("mav set", 8'h01, {7'h00, mav});
      rx_chk(c0, 2, 8'h0A, 1'b1); chk8("opc char", 8'h31, rprev);
      chk8("mav", 8'h00, {7'h00, mav});
      end_of_test();
   end
endmodule : gsr_status_tb_top
